// ===== hdl/pmi_params.svh
/*
 * Constants of the port pattern match interrupt unit: register offsets,
 * field positions, reset values and the qualification time.
 * Assumes a 20 MHz APB clock and an 8-bit input port.
 */
// Notes on behaviour
// - Only port pins with their mask bit set can raise the match interrupt.
// - Port value is compared every cycle against the match pattern register.
// - Flag sets when the chosen match condition becomes true while active.
// - Flag set with enable on gives one interrupt request.
// - Polarity select 1 means trigger on not-equal, 0 means equal.
// - An enabled match wakes the core from Idle or Power-down.
// - Match must persist longer than six core clocks; shorter ones ignored.
`ifndef PMI_PARAMS_SVH
`define PMI_PARAMS_SVH

`define PMI_OFS_MASK      12'h000
`define PMI_OFS_PATTERN   12'h004
`define PMI_OFS_CONTROL   12'h008
`define PMI_OFS_STATUS    12'h00c
`define PMI_OFS_IRQ_EN    12'h010
`define PMI_OFS_IRQ_CLR   12'h014

`define PMI_CTL_FLAG      0
`define PMI_CTL_POLARITY  1
`define PMI_CTL_ACTIVE    2

`define PMI_RST_MASK      8'h00
`define PMI_RST_PATTERN   8'hff

`define PMI_HOLD_CYCLES   6
`define PMI_CLK_NS        50

`endif

// ===== hdl/pmi_pkg.sv
/*
 * Types of the port pattern match interrupt unit.
 * Assumes nothing beyond the constants header.
 */
package pmi_pkg;
    typedef enum logic [2:0] {
        PMI_IDLE    = 3'b001,
        PMI_QUALIFY = 3'b010,
        PMI_HELD    = 3'b100
    } pmi_state_e;
endpackage

// ===== hdl/pmi_port_match.sv
/*
 * Port pattern match interrupt unit with an APB register slave.
 * Assumes port pins are asynchronous to pclk and a single pclk domain;
 * the power control outside uses wake_req to leave Idle or Power-down.
 */
// The register addresses and the APB slave port were left to the implementer.
`timescale 1ns/1ns
`include "pmi_params.svh"

module pmi_port_match #(
    parameter int PORT_W = 8
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              clk_en,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic [PORT_W-1:0] port_pins,
    output logic                   port_match_interrupt,
    output logic                   wake_req
);

    localparam logic [3:0] HOLD_N = 4'(`PMI_HOLD_CYCLES);

    // Refused at elaboration: the registers hold at most one 32-bit word
    if (PORT_W < 1 || PORT_W > 32) begin : g_bad_width
        $error("PORT_W must lie in 1..32");
    end

    logic [PORT_W-1:0] sync1_q;
    logic [PORT_W-1:0] sync2_q;
    logic [PORT_W-1:0] key_pin_mask_q;
    logic [PORT_W-1:0] key_match_pattern_q;
    logic              match_polarity_select_q;
    logic              active_q;
    logic              key_match_flag_q;
    logic              irq_en_q;
    logic [3:0]        hold_cnt_q;
    pmi_pkg::pmi_state_e state_q;

    logic              acc;
    logic              wr;
    logic              rd;
    logic              mapped;
    logic              differ;
    logic              cond;
    logic              qualified;
    logic              flag_clr;

    assign acc = psel && penable && clk_en;
    assign wr  = acc && pwrite;
    assign rd  = acc && !pwrite;
    assign mapped = (paddr == `PMI_OFS_MASK) || (paddr == `PMI_OFS_PATTERN) ||
                    (paddr == `PMI_OFS_CONTROL) || (paddr == `PMI_OFS_STATUS) ||
                    (paddr == `PMI_OFS_IRQ_EN) || (paddr == `PMI_OFS_IRQ_CLR);

    // Port pins pass two flops before comparison
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else if (clk_en) begin
            sync1_q <= port_pins;
            sync2_q <= sync1_q;
        end
    end

    // Masked pins never differ from the pattern
    assign differ = |((sync2_q ^ key_match_pattern_q) & key_pin_mask_q);
    // An all-zero mask in not-equal mode can never match, which is wanted
    assign cond = active_q && (match_polarity_select_q ? differ : !differ);

    // Qualification filter: cond must stand more than HOLD_N cycles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q    <= pmi_pkg::PMI_IDLE;
            hold_cnt_q <= 4'h0;
        end else if (clk_en) begin
            case (state_q)
                pmi_pkg::PMI_IDLE: begin
                    hold_cnt_q <= 4'h0;
                    if (cond) begin
                        state_q <= pmi_pkg::PMI_QUALIFY;
                    end
                end
                pmi_pkg::PMI_QUALIFY: begin
                    if (!cond) begin
                        state_q <= pmi_pkg::PMI_IDLE;
                    end else if (hold_cnt_q == HOLD_N - 4'h1) begin
                        state_q <= pmi_pkg::PMI_HELD;
                    end else begin
                        hold_cnt_q <= hold_cnt_q + 4'h1;
                    end
                end
                pmi_pkg::PMI_HELD: begin
                    if (!cond) begin
                        state_q <= pmi_pkg::PMI_IDLE;
                    end
                end
                default: begin
                    state_q <= pmi_pkg::PMI_IDLE;
                end
            endcase
        end
    end

    // Flag sets once per qualified match, not on every cycle it stays true
    assign qualified = clk_en && (state_q == pmi_pkg::PMI_QUALIFY) && cond &&
                       (hold_cnt_q == HOLD_N - 4'h1);

    assign flag_clr = wr && (((paddr == `PMI_OFS_CONTROL) && !pwdata[`PMI_CTL_FLAG]) ||
                             ((paddr == `PMI_OFS_IRQ_CLR) && pwdata[0]));

    // Set wins over a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            key_match_flag_q <= 1'b0;
        end else if (qualified) begin
            key_match_flag_q <= 1'b1;
        end else if (flag_clr) begin
            key_match_flag_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            key_pin_mask_q          <= PORT_W'(`PMI_RST_MASK);
            key_match_pattern_q     <= PORT_W'(`PMI_RST_PATTERN);
            match_polarity_select_q <= 1'b0;
            active_q                <= 1'b0;
            irq_en_q                <= 1'b0;
        end else if (wr) begin
            case (paddr)
                `PMI_OFS_MASK: begin
                    key_pin_mask_q <= pwdata[PORT_W-1:0];
                end
                `PMI_OFS_PATTERN: begin
                    key_match_pattern_q <= pwdata[PORT_W-1:0];
                end
                `PMI_OFS_CONTROL: begin
                    match_polarity_select_q <= pwdata[`PMI_CTL_POLARITY];
                    active_q                <= pwdata[`PMI_CTL_ACTIVE];
                end
                `PMI_OFS_IRQ_EN: begin
                    irq_en_q <= pwdata[0];
                end
                default: begin
                end
            endcase
        end
    end

    // Outputs registered; interrupt and wake follow flag and enable one cycle later
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_match_interrupt <= 1'b0;
            wake_req             <= 1'b0;
        end else if (clk_en) begin
            port_match_interrupt <= key_match_flag_q && irq_en_q;
            wake_req             <= key_match_flag_q && irq_en_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else if (clk_en) begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            prdata  <= 32'h0000_0000;
            if (psel && !penable && !pwrite) begin
                case (paddr)
                    `PMI_OFS_MASK:    prdata <= 32'(key_pin_mask_q);
                    `PMI_OFS_PATTERN: prdata <= 32'(key_match_pattern_q);
                    `PMI_OFS_CONTROL: prdata <= {29'h0, active_q, match_polarity_select_q, key_match_flag_q};
                    `PMI_OFS_STATUS:  prdata <= {31'h0, key_match_flag_q};
                    `PMI_OFS_IRQ_EN:  prdata <= {31'h0, irq_en_q};
                    default:          prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    logic unused_rd;
    assign unused_rd = rd;

    a_flag_needs_hold: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(key_match_flag_q) |-> $past(cond, 1) && $past(cond, 2) && $past(cond, 3) &&
            $past(cond, 4) && $past(cond, 5) && $past(cond, 6) && $past(cond, 7))
        else $error("flag set without a match held seven cycles");

    a_mask_gates_pins: assert property (@(posedge pclk) disable iff (!presetn)
        (key_pin_mask_q == '0) && clk_en |-> !differ)
        else $error("masked pin took part in comparison");

    a_polarity_equal: assert property (@(posedge pclk) disable iff (!presetn)
        active_q && !match_polarity_select_q && (sync2_q == key_match_pattern_q) |-> cond)
        else $error("equal match not seen");

    a_inactive_no_flag: assert property (@(posedge pclk) disable iff (!presetn)
        !active_q [*8] |=> !$rose(key_match_flag_q))
        else $error("flag set while function inactive");

    a_flag_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        key_match_flag_q && !flag_clr |=> key_match_flag_q)
        else $error("flag dropped without software clear");

    a_irq_follows: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && key_match_flag_q && irq_en_q |=> port_match_interrupt)
        else $error("interrupt not raised for enabled flag");

    a_wake_follows: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && !(key_match_flag_q && irq_en_q) |=> !wake_req)
        else $error("wake without enabled flag");

    a_short_ignored: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && !cond ##1 clk_en && cond [*3] ##1 clk_en && !cond |=> !$rose(key_match_flag_q))
        else $error("short match set the flag");

    // Checker-only run length of cond; saturates so a long hold never wraps
    logic [3:0] cond_run_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cond_run_q <= 4'h0;
        end else if (clk_en) begin
            if (!cond) begin
                cond_run_q <= 4'h0;
            end else if (cond_run_q != 4'hf) begin
                cond_run_q <= cond_run_q + 4'h1;
            end
        end
    end

    a_run_before_flag: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(key_match_flag_q) |-> (cond_run_q >= HOLD_N + 4'h1))
        else $error("flag set after a run shorter than seven cycles");

    a_long_sets: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && !cond ##1 (clk_en && cond) [*7] |=> key_match_flag_q)
        else $error("seven-cycle match did not set the flag");

    a_hold_bound: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q == pmi_pkg::PMI_QUALIFY) |-> (hold_cnt_q < HOLD_N))
        else $error("hold counter ran past its limit");

    a_state_onehot: assert property (@(posedge pclk) disable iff (!presetn)
        $onehot(state_q))
        else $error("filter state not one-hot");

    a_frozen_filter: assert property (@(posedge pclk) disable iff (!presetn)
        !clk_en |=> $stable(state_q) && $stable(hold_cnt_q) && $stable(key_match_flag_q))
        else $error("filter moved while clock enable low");

    a_sync_stage: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en |=> (sync2_q == $past(sync1_q)))
        else $error("second sync stage skipped");

    a_inactive_no_cond: assert property (@(posedge pclk) disable iff (!presetn)
        !active_q |-> !cond)
        else $error("match condition while inactive");

    a_notequal_match: assert property (@(posedge pclk) disable iff (!presetn)
        active_q && match_polarity_select_q && differ |-> cond)
        else $error("not-equal match not seen");

    a_equal_miss: assert property (@(posedge pclk) disable iff (!presetn)
        active_q && !match_polarity_select_q && differ |-> !cond)
        else $error("equal mode matched a differing port");

    a_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
        qualified |=> key_match_flag_q)
        else $error("qualified match did not set the flag");

    a_flag_clears: assert property (@(posedge pclk) disable iff (!presetn)
        flag_clr && !qualified |=> !key_match_flag_q)
        else $error("software clear ignored");

    a_status_ro: assert property (@(posedge pclk) disable iff (!presetn)
        wr && (paddr == `PMI_OFS_STATUS) && !qualified |=> $stable(key_match_flag_q))
        else $error("status write changed the flag");

    a_write_mask: assert property (@(posedge pclk) disable iff (!presetn)
        wr && (paddr == `PMI_OFS_MASK) |=> (key_pin_mask_q == $past(pwdata[PORT_W-1:0])))
        else $error("mask write lost");

    a_write_pattern: assert property (@(posedge pclk) disable iff (!presetn)
        wr && (paddr == `PMI_OFS_PATTERN) |=> (key_match_pattern_q == $past(pwdata[PORT_W-1:0])))
        else $error("pattern write lost");

    a_write_polarity: assert property (@(posedge pclk) disable iff (!presetn)
        wr && (paddr == `PMI_OFS_CONTROL) |=> (match_polarity_select_q == $past(pwdata[`PMI_CTL_POLARITY])))
        else $error("polarity write lost");

    a_irq_clears: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && !(key_match_flag_q && irq_en_q) |=> !port_match_interrupt)
        else $error("interrupt without enabled flag");

    a_wake_rises: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && key_match_flag_q && irq_en_q |=> wake_req)
        else $error("wake not raised for enabled flag");

    a_wake_irq_same: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |-> (wake_req == port_match_interrupt))
        else $error("wake and interrupt disagree");

    a_pready_answers: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && psel && !penable |=> pready)
        else $error("no ready in access cycle");

    a_pready_single: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && !(psel && !penable) |=> !pready)
        else $error("ready outside access cycle");

    a_slverr_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && psel && !penable && !mapped |=> pslverr)
        else $error("unmapped access without error");

    a_slverr_mapped: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && psel && !penable && mapped |=> !pslverr)
        else $error("error on mapped access");

    a_prdata_idle: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && !(psel && !penable && !pwrite) |=> (prdata == 32'h0000_0000))
        else $error("read data outside a read");

    a_read_mask: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && psel && !penable && !pwrite && (paddr == `PMI_OFS_MASK) |=>
            (prdata[PORT_W-1:0] == $past(key_pin_mask_q)))
        else $error("mask read back wrong");

    a_read_status: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && psel && !penable && !pwrite && (paddr == `PMI_OFS_STATUS) |=>
            (prdata == {31'h0, $past(key_match_flag_q)}))
        else $error("status read back wrong");

endmodule

// ===== tb/pmi_keypad_model.sv
/*
 * Keypad on the eight port pins: a pressed key pulls its line low.
 * Assumes pull-ups, so released lines and idle pins read high.
 */
`timescale 1ns/1ns

module pmi_keypad_model (
    input  wire logic       pclk,
    output logic      [7:0] pins
);
    initial pins = 8'hff;

    // Holds a pattern for a number of clocks, short or long
    task automatic show(input logic [7:0] v, input int cycles);
        @(posedge pclk);
        pins <= v;
        repeat (cycles) @(posedge pclk);
        pins <= 8'hff;
    endtask
endmodule

// ===== tb/test_port_pattern_match_interrupt.sv
/*
 * Bench of the port pattern match unit: APB master tasks, a keypad model
 * and an integer reference of the match. Assumes the hdl/ design files.
 */
`timescale 1ns/1ns
`include "pmi_params.svh"

module test_port_pattern_match_interrupt;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        clk_en = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [7:0]  pins;
    logic        irq;
    logic        wake;
    logic [31:0] rng = 32'h8ae21d96;
    logic [31:0] rdata;
    logic        serr;
    logic [31:0] r;
    int          m;
    int          pat;
    int          pol;
    int          en;
    int          v;
    int          failures = 0;
    int          tests_run = 0;

    always #25 pclk = ~pclk;

    pmi_port_match dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .port_pins(pins), .port_match_interrupt(irq), .wake_req(wake));
    pmi_keypad_model kp (.pclk(pclk), .pins(pins));

    function automatic logic [31:0] xs();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction

    function automatic int ref_flag(int pv, int pp, int pm, int pl);
        return ((((pv ^ pp) & pm) != 0) == (pl != 0)) ? 1 : 0;
    endfunction

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1);
        rdata = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        check("wait states", 32'h1, n);
    endtask

    task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(what, exp, rdata);
    endtask

    task automatic expect_flag(input int f, input int e);
        rdchk("status", `PMI_OFS_STATUS, f);
        check("interrupt", f & e, irq);
        check("wake", f & e, wake);
    endtask

    // Deactivate first so the control write also clears an old flag
    task automatic setup(input int sm, input int sp, input int sl, input int se);
        apb(1'b1, `PMI_OFS_CONTROL, sl << `PMI_CTL_POLARITY);
        apb(1'b1, `PMI_OFS_MASK, sm);
        apb(1'b1, `PMI_OFS_PATTERN, sp);
        apb(1'b1, `PMI_OFS_IRQ_EN, se);
        apb(1'b1, `PMI_OFS_CONTROL, (sl << `PMI_CTL_POLARITY) | (1 << `PMI_CTL_ACTIVE));
    endtask

    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        #(`PMI_CLK_NS * 20000);
        failures++;
        print_verdict();
    end

    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rdchk("mask", `PMI_OFS_MASK, `PMI_RST_MASK);
        rdchk("pattern", `PMI_OFS_PATTERN, `PMI_RST_PATTERN);
        rdchk("control", `PMI_OFS_CONTROL, 32'h0);
        rdchk("irq enable", `PMI_OFS_IRQ_EN, 32'h0);
        apb(1'b1, `PMI_OFS_STATUS, 32'h1);
        expect_flag(0, 0);
        apb(1'b0, 12'h018, 32'h0);
        check("unmapped data", 32'h0, rdata);
        check("unmapped error", 32'h1, serr);
        setup(8'h0f, 8'hff, 1, 1);
        kp.show(8'hdf, 20);
        expect_flag(0, 1);
        kp.show(8'hfb, 6);
        expect_flag(0, 1);
        kp.show(8'hfb, 12);
        expect_flag(1, 1);
        apb(1'b1, `PMI_OFS_IRQ_CLR, 32'h1);
        expect_flag(0, 1);
        kp.show(8'hfe, 12);
        apb(1'b1, `PMI_OFS_CONTROL, 32'h6);
        expect_flag(0, 1);
        // Frozen clock enable: a long key press must leave no trace
        clk_en <= 1'b0;
        kp.show(8'hfe, 12);
        clk_en <= 1'b1;
        expect_flag(0, 1);
        for (int i = 0; i < 24; i++) begin
            r = xs();
            m = r[7:0];
            pat = r[15:8];
            pol = r[16];
            en = r[17];
            v = r[18] ? ((pat ^ (r[31:24] & ~m)) & 'hff) : r[31:24];
            setup(m, pat, pol, en);
            kp.show(v[7:0], 12);
            expect_flag(ref_flag(v, pat, m, pol), en);
        end
        print_verdict();
    end
endmodule
